// ---- verilog/cfg_cmd_interp.sv ----
// Configuration-mode command interpreter
// Summary of operation
// - Setup pin driven low enters configuration mode.
// - Prompt character is sent after each finished command except exit with setup pin high.
// - Exit with setup pin high sends no prompt, requests power-on reset, returns normal.
// - Unknown command bytes are ignored and answered with a prompt.
// - Commands as ASCII or binary byte; arguments always binary.
// - Signal strength command returns one byte.
// - Temperature and supply commands each return one byte.
// - Read command returns configuration byte at address 0x00-0x7F.
// - Memory write command stores address/data pairs persistently.
// - Prompt after command, silent on pairs, 0xFF ends, prompt after storage.
// - After write sequence, stay in configuration mode until exit.
// - Two-byte reset command restores factory configuration memory.
// - Role commands set router, gateway or end node.
// - Sleep command acts only while setup pin is low.
// - Key command, index 0x37, sixteen bytes store key seven.
// - Two-byte calibration command writes pairs, ended by 0xFF.
// - List commands output all calibration or configuration bytes.
// - Test carrier, receive test, sniffers; any byte ends sniffing.
// - Remote writes to radio identity only while identifier is factory.
// - Gateway also enters configuration mode on serial request.
// - Response begins within 10 us of the command byte.
`timescale 1ns/10ps
module cfg_cmd_interp #(
  parameter int CLKS_PER_BIT = cfgcmd_pkg::CLKS_PER_BIT,
  parameter int MEM_PROG_CYCLES = cfgcmd_pkg::MEM_PROG_CYC,
  parameter int EXIT_CYCLES = cfgcmd_pkg::EXIT_CYC
) (
  input wire logic clk, // 200 MHz clock
  input wire logic rst_n, // Async reset
  input wire logic ce, // Clock enable
  input wire logic rxd, // Serial in from host
  output logic txd, // Serial out to host
  input wire logic cfg_n, // Setup-mode pin
  input wire logic gw_cfg_req, // Serial config request pulse
  input wire logic [7:0] rssi, // Signal strength
  input wire logic [7:0] temperature, // Temperature value
  input wire logic [7:0] supply, // Supply value
  input wire logic pkt_valid, // Valid packet pulse
  input wire logic [7:0] pkt_rssi, // Packet strength
  input wire logic [7:0] pkt_info, // Packet details
  input wire logic remote_valid, // Remote write pulse
  input wire logic [7:0] remote_addr, // Remote write address
  input wire logic [7:0] remote_data, // Remote write data
  output logic remote_denied, // Remote write refused
  output logic cfg_active, // In configuration mode
  output cfgcmd_pkg::role_t role, // Node role
  output cfgcmd_pkg::test_t test_mode, // Radio test mode
  output logic sleep, // Sleep request
  output logic por_req, // Power-on reset pulse
  output logic nvm_busy, // Storage in progress
  output logic [127:0] key_data, // Key number seven
  output logic key_valid, // Key loaded
  output logic [cfgcmd_pkg::CFG_DEPTH*8-1:0] cfg_image, // Config memory
  output logic [cfgcmd_pkg::CAL_DEPTH*8-1:0] cal_image // Calibration memory
);
  import cfgcmd_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [4:0] {ST_NORMAL, ST_IDLE, ST_PROMPT, ST_RESP, ST_RADDR,
    ST_WADDR, ST_WDATA, ST_PROG, ST_AT2, ST_H2, ST_KIDX, ST_KEY, ST_LIST,
    ST_SNIFF, ST_SLEEP, ST_EXIT} st_t;

  typedef struct packed {
    st_t st;
    st_t ret;
    st_t pret;
    logic p1, p2, p3, pin_low;
    logic cfg;
    logic [CFG_DEPTH-1:0][7:0] cfg_mem;
    logic [CAL_DEPTH-1:0][7:0] cal_mem;
    logic [KEY_BYTES-1:0][7:0] key;
    logic key_ok;
    role_t role;
    test_t test;
    logic sleep;
    logic por;
    logic denied;
    logic [31:0] cnt;
    logic [7:0] idx;
    logic [7:0] addr;
    logic cal_sel;
    logic [7:0] resp;
    logic [7:0] resp2;
    logic two;
    logic stop;
  } top_t;
  top_t r, n;

  byte_if rx_bus();
  byte_if tx_bus();

  function automatic logic id_field(input logic [7:0] a);
    id_field = (a == CHAN_ADDR) || (a == RATE_ADDR) ||
      (a >= MADDR_BASE && a < MADDR_BASE + 8'h4) ||
      (a >= NID_BASE && a < NID_BASE + 8'h4);
  endfunction : id_field

  function automatic logic nid_factory(input logic [CFG_DEPTH-1:0][7:0] m);
    nid_factory = {m[NID_BASE], m[NID_BASE + 8'h1], m[NID_BASE + 8'h2],
      m[NID_BASE + 8'h3]} == NID_FACTORY;
  endfunction : nid_factory

  // ****************************************************************
  // Serial ports
  // ****************************************************************
  uart_rx #(.CLKS_PER_BIT(CLKS_PER_BIT)) u_rx (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .rxd(rxd),
    .bus(rx_bus.src)
  );

  uart_tx #(.CLKS_PER_BIT(CLKS_PER_BIT)) u_tx (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .bus(tx_bus.snk),
    .txd(txd)
  );

  logic rxv;
  logic [7:0] rxb;
  logic fire;
  logic [7:0] list_byte;

  assign rx_bus.ready = 1'b1;
  assign rxv = rx_bus.valid;
  assign rxb = rx_bus.data;
  assign list_byte = r.cal_sel ? r.cal_mem[r.idx[4:0]] : r.cfg_mem[r.idx[6:0]];
  assign tx_bus.valid = (r.st == ST_PROMPT) || (r.st == ST_RESP) ||
    (r.st == ST_LIST);
  assign tx_bus.data = (r.st == ST_PROMPT) ? PROMPT_CHAR :
    (r.st == ST_RESP) ? r.resp : list_byte;
  assign fire = tx_bus.valid && tx_bus.ready;

  assign remote_denied = r.denied;
  assign cfg_active = r.cfg;
  assign role = r.role;
  assign test_mode = r.test;
  assign sleep = r.sleep;
  assign por_req = r.por;
  assign nvm_busy = (r.st == ST_PROG);
  assign key_data = r.key;
  assign key_valid = r.key_ok;
  assign cfg_image = r.cfg_mem;
  assign cal_image = r.cal_mem;

  // ****************************************************************
  // Command decoder
  // ****************************************************************
  always_comb begin
    n = r;
    n.por = 1'b0;
    n.denied = 1'b0;
    n.p1 = cfg_n;
    n.p2 = r.p1;
    n.p3 = r.p2;
    if (r.p2 == r.p3) begin
      n.pin_low = ~r.p3;
    end
    if (remote_valid && remote_addr < 8'(CFG_DEPTH)) begin
      if (id_field(remote_addr) && !nid_factory(r.cfg_mem)) begin
        n.denied = 1'b1;
      end else begin
        n.cfg_mem[remote_addr[6:0]] = remote_data;
      end
    end
    case (r.st)
      ST_NORMAL: begin
        if ((r.pin_low && !r.p3) ||
            (gw_cfg_req && r.role == ROLE_GATEWAY)) begin
          n.cfg = 1'b1;
          n.st = ST_PROMPT;
          n.pret = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (rxv) begin
          n.st = ST_PROMPT;
          n.pret = ST_IDLE;
          n.ret = ST_PROMPT;
          n.two = 1'b0;
          case (rxb)
            CMD_RSSI: begin
              n.resp = rssi;
              n.st = ST_RESP;
            end
            CMD_TEMP: begin
              n.resp = temperature;
              n.st = ST_RESP;
            end
            CMD_VCC: begin
              n.resp = supply;
              n.st = ST_RESP;
            end
            CMD_READ: n.st = ST_RADDR;
            CMD_MEMW: begin
              n.cal_sel = 1'b0;
              n.pret = ST_WADDR;
            end
            CMD_AT: n.st = ST_AT2;
            CMD_CAL_H: n.st = ST_H2;
            CMD_KEY: n.st = ST_KIDX;
            CMD_EXIT: begin
              if (!r.pin_low) begin
                n.por = 1'b1;
                n.cnt = 32'h0;
                n.st = ST_EXIT;
              end
            end
            CMD_ROUTER: n.role = ROLE_ROUTER;
            CMD_GATEWAY: n.role = ROLE_GATEWAY;
            CMD_ENDNODE: n.role = ROLE_END;
            CMD_SLEEP: begin
              if (r.pin_low) begin
                n.sleep = 1'b1;
                n.st = ST_SLEEP;
              end
            end
            CMD_LIST_CAL: begin
              n.cal_sel = 1'b1;
              n.idx = 8'h0;
              n.st = ST_LIST;
            end
            CMD_LIST_CFG: begin
              n.cal_sel = 1'b0;
              n.idx = 8'h0;
              n.st = ST_LIST;
            end
            CMD_TX_CARRIER: n.test = TEST_CARRIER;
            CMD_RX_TEST: n.test = TEST_RX;
            CMD_SNIFF1: begin
              n.test = TEST_SNIFF1;
              n.stop = 1'b0;
              n.st = ST_SNIFF;
            end
            CMD_SNIFF2: begin
              n.test = TEST_SNIFF2;
              n.stop = 1'b0;
              n.st = ST_SNIFF;
            end
            default: n.st = ST_PROMPT;
          endcase
        end
      end
      ST_PROMPT: begin
        if (fire) begin
          n.st = r.pret;
        end
      end
      ST_RESP: begin
        if (r.test inside {TEST_SNIFF1, TEST_SNIFF2} && rxv) begin
          n.stop = 1'b1;
        end
        if (fire) begin
          if (r.two) begin
            n.resp = r.resp2;
            n.two = 1'b0;
          end else begin
            n.st = r.ret;
          end
        end
      end
      ST_RADDR: begin
        if (rxv) begin
          if (rxb < 8'(CFG_DEPTH)) begin
            n.resp = r.cfg_mem[rxb[6:0]];
            n.ret = ST_PROMPT;
            n.st = ST_RESP;
          end else begin
            n.st = ST_PROMPT;
          end
          n.pret = ST_IDLE;
        end
      end
      ST_WADDR: begin
        if (rxv) begin
          if (rxb == MEMW_END) begin
            n.cnt = 32'h0;
            n.st = ST_PROG;
          end else begin
            n.addr = rxb;
            n.st = ST_WDATA;
          end
        end
      end
      ST_WDATA: begin
        if (rxv) begin
          if (r.cal_sel && r.addr < 8'(CAL_DEPTH)) begin
            n.cal_mem[r.addr[4:0]] = rxb;
          end else if (!r.cal_sel && r.addr < 8'(CFG_DEPTH)) begin
            n.cfg_mem[r.addr[6:0]] = rxb;
          end
          n.st = ST_WADDR;
        end
      end
      ST_PROG: begin
        n.cnt = r.cnt + 32'h1;
        if (r.cnt == 32'(MEM_PROG_CYCLES - 1)) begin
          n.st = ST_PROMPT;
          n.pret = ST_IDLE;
        end
      end
      ST_AT2: begin
        if (rxv) begin
          n.pret = ST_IDLE;
          n.st = ST_PROMPT;
          if (rxb == CMD_AT_T) begin
            n.cfg_mem = FACTORY_CFG;
            n.cnt = 32'h0;
            n.st = ST_PROG;
          end
        end
      end
      ST_H2: begin
        if (rxv) begin
          n.st = ST_PROMPT;
          n.cal_sel = 1'b1;
          n.pret = (rxb == CMD_CAL_W) ? ST_WADDR : ST_IDLE;
        end
      end
      ST_KIDX: begin
        if (rxv) begin
          n.idx = 8'h0;
          n.st = ST_PROMPT;
          n.pret = (rxb == KEY_INDEX) ? ST_KEY : ST_IDLE;
        end
      end
      ST_KEY: begin
        if (rxv) begin
          n.key[4'(KEY_BYTES - 1) - r.idx[3:0]] = rxb;
          n.idx = r.idx + 8'h1;
          if (r.idx == 8'(KEY_BYTES - 1)) begin
            n.key_ok = 1'b1;
            n.st = ST_PROMPT;
            n.pret = ST_IDLE;
          end
        end
      end
      ST_LIST: begin
        if (fire) begin
          n.idx = r.idx + 8'h1;
          if (r.idx == (r.cal_sel ? 8'(CAL_DEPTH - 1) : 8'(CFG_DEPTH - 1))) begin
            n.st = ST_PROMPT;
            n.pret = ST_IDLE;
          end
        end
      end
      ST_SNIFF: begin
        if (rxv || r.stop) begin
          n.test = TEST_RX;
          n.stop = 1'b0;
          n.st = ST_PROMPT;
          n.pret = ST_IDLE;
        end else if (pkt_valid) begin
          n.resp = pkt_rssi;
          n.resp2 = pkt_info;
          n.two = (r.test == TEST_SNIFF2);
          n.ret = ST_SNIFF;
          n.st = ST_RESP;
        end
      end
      ST_SLEEP: begin
        if (!r.pin_low) begin
          n.sleep = 1'b0;
          n.st = ST_PROMPT;
          n.pret = ST_IDLE;
        end
      end
      default: begin
        n.cnt = r.cnt + 32'h1;
        if (r.cnt == 32'(EXIT_CYCLES - 1)) begin
          n.cfg = 1'b0;
          n.test = TEST_OFF;
          n.st = ST_NORMAL;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.p1 <= 1'b1;
      r.p2 <= 1'b1;
      r.p3 <= 1'b1;
      r.cfg_mem <= FACTORY_CFG;
    end else if (ce) begin
      r <= n;
    end
  end
endmodule : cfg_cmd_interp

// ---- verilog/cfgcmd_pkg.sv ----
// Shared constants and types for the configuration command interpreter
package cfgcmd_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 200;
  localparam int BAUD = 19200;
  localparam int CLKS_PER_BIT = CLK_MHZ * 1000000 / BAUD;
  localparam int RESP_TIME_NS = 10000;
  localparam int RESP_CYC = RESP_TIME_NS * CLK_MHZ / 1000;
  localparam int MEM_PROG_MS = 24;
  localparam int MEM_PROG_CYC = MEM_PROG_MS * CLK_MHZ * 1000;
  localparam int EXIT_MS = 1;
  localparam int EXIT_CYC = EXIT_MS * CLK_MHZ * 1000;

  // ****************************************************************
  // Command codes
  // ****************************************************************
  localparam logic [7:0] CMD_RSSI = 8'h53;
  localparam logic [7:0] CMD_TEMP = 8'h55;
  localparam logic [7:0] CMD_VCC = 8'h56;
  localparam logic [7:0] CMD_READ = 8'h59;
  localparam logic [7:0] CMD_MEMW = 8'h4d;
  localparam logic [7:0] CMD_AT = 8'h40;
  localparam logic [7:0] CMD_AT_T = 8'h54;
  localparam logic [7:0] CMD_EXIT = 8'h58;
  localparam logic [7:0] CMD_ROUTER = 8'h52;
  localparam logic [7:0] CMD_GATEWAY = 8'h47;
  localparam logic [7:0] CMD_ENDNODE = 8'h4e;
  localparam logic [7:0] CMD_SLEEP = 8'h5a;
  localparam logic [7:0] CMD_KEY = 8'h4b;
  localparam logic [7:0] KEY_INDEX = 8'h37;
  localparam logic [7:0] CMD_CAL_H = 8'h48;
  localparam logic [7:0] CMD_CAL_W = 8'h57;
  localparam logic [7:0] CMD_LIST_CAL = 8'h72;
  localparam logic [7:0] CMD_LIST_CFG = 8'h30;
  localparam logic [7:0] CMD_TX_CARRIER = 8'h31;
  localparam logic [7:0] CMD_RX_TEST = 8'h33;
  localparam logic [7:0] CMD_SNIFF1 = 8'h35;
  localparam logic [7:0] CMD_SNIFF2 = 8'h36;
  localparam logic [7:0] PROMPT_CHAR = 8'h3e;
  localparam logic [7:0] MEMW_END = 8'hff;

  // ****************************************************************
  // Memories
  // ****************************************************************
  localparam int CFG_DEPTH = 128;
  localparam int CAL_DEPTH = 32;
  localparam int KEY_BYTES = 16;
  localparam logic [7:0] CHAN_ADDR = 8'h00;
  localparam logic [7:0] RATE_ADDR = 8'h03;
  localparam logic [7:0] MADDR_BASE = 8'h14;
  localparam logic [7:0] NID_BASE = 8'h18;
  localparam logic [31:0] NID_FACTORY = 32'h00000001;
  localparam logic [CFG_DEPTH*8-1:0] FACTORY_CFG =
    (CFG_DEPTH*8)'(NID_FACTORY[7:0]) << (8 * (int'(NID_BASE) + 3));

  typedef enum logic [1:0] {ROLE_ROUTER, ROLE_GATEWAY, ROLE_END} role_t;
  typedef enum logic [2:0] {TEST_OFF, TEST_CARRIER, TEST_RX, TEST_SNIFF1,
    TEST_SNIFF2} test_t;
endpackage : cfgcmd_pkg

// ---- verilog/byte_if.sv ----
// Byte stream carrier with valid and ready
`timescale 1ns/10ps
interface byte_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : byte_if

// ---- verilog/uart_rx.sv ----
// Serial receiver with three-stage input synchroniser
`timescale 1ns/10ps
module uart_rx #(
  parameter int CLKS_PER_BIT = cfgcmd_pkg::CLKS_PER_BIT
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset
  input wire logic ce, // Clock enable
  input wire logic rxd, // Serial line in
  byte_if.src bus // Received bytes
);
  import cfgcmd_pkg::*;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_st_t;
  typedef struct packed {
    logic s1, s2, s3, line;
    rx_st_t st;
    logic [15:0] cnt;
    logic [2:0] bitn;
    logic [7:0] sh;
    logic valid;
  } rx_t;
  rx_t r, n;
  localparam logic [15:0] FULL = 16'(CLKS_PER_BIT - 1);
  localparam logic [15:0] HALF = 16'(CLKS_PER_BIT / 2);

  assign bus.valid = r.valid;
  assign bus.data = r.sh;

  always_comb begin
    n = r;
    n.s1 = rxd;
    n.s2 = r.s1;
    n.s3 = r.s2;
    if (r.s2 == r.s3) begin
      n.line = r.s3;
    end
    if (bus.ready) begin
      n.valid = 1'b0;
    end
    n.cnt = r.cnt + 16'h1;
    case (r.st)
      RX_IDLE: begin
        n.cnt = 16'h0;
        if (!r.line) begin
          n.st = RX_START;
        end
      end
      RX_START: begin
        if (r.cnt == HALF) begin
          n.cnt = 16'h0;
          n.bitn = 3'h0;
          n.st = r.line ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (r.cnt == FULL) begin
          n.cnt = 16'h0;
          n.sh = {r.line, r.sh[7:1]};
          n.bitn = r.bitn + 3'h1;
          if (r.bitn == 3'h7) begin
            n.st = RX_STOP;
          end
        end
      end
      default: begin
        if (r.cnt == FULL) begin
          n.valid = r.line;
          n.st = RX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.s1 <= 1'b1;
      r.s2 <= 1'b1;
      r.s3 <= 1'b1;
      r.line <= 1'b1;
    end else if (ce) begin
      r <= n;
    end
  end
endmodule : uart_rx

// ---- verilog/uart_tx.sv ----
// Serial transmitter, 8N1
`timescale 1ns/10ps
module uart_tx #(
  parameter int CLKS_PER_BIT = cfgcmd_pkg::CLKS_PER_BIT
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset
  input wire logic ce, // Clock enable
  byte_if.snk bus, // Bytes to send
  output logic txd // Serial line out
);
  import cfgcmd_pkg::*;
  typedef struct packed {
    logic busy;
    logic [15:0] cnt;
    logic [3:0] bitn;
    logic [9:0] sh;
  } tx_t;
  tx_t r, n;
  localparam logic [15:0] FULL = 16'(CLKS_PER_BIT - 1);

  assign bus.ready = !r.busy;
  assign txd = r.sh[0];

  always_comb begin
    n = r;
    if (!r.busy) begin
      if (bus.valid) begin
        n.busy = 1'b1;
        n.sh = {1'b1, bus.data, 1'b0};
        n.cnt = 16'h0;
        n.bitn = 4'h0;
      end
    end else if (r.cnt == FULL) begin
      n.cnt = 16'h0;
      n.sh = {1'b1, r.sh[9:1]};
      n.bitn = r.bitn + 4'h1;
      if (r.bitn == 4'h9) begin
        n.busy = 1'b0;
      end
    end else begin
      n.cnt = r.cnt + 16'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.sh <= 10'h3ff;
    end else if (ce) begin
      r <= n;
    end
  end
endmodule : uart_tx

// ---- sim/cfg_cmd_interp_props.sv ----
// Concurrent checks on the interpreter's top ports
`timescale 1ns/10ps
module cfg_cmd_interp_props #(
  parameter int MEM_PROG_CYCLES = 20,
  parameter int EXIT_CYCLES = 10
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic txd, // Serial out
  input wire logic cfg_n, // Setup pin
  input wire logic remote_valid, // Remote write
  input wire logic [7:0] remote_addr, // Remote address
  input wire logic remote_denied, // Refused
  input wire logic cfg_active, // Config mode
  input wire cfgcmd_pkg::role_t role, // Role
  input wire cfgcmd_pkg::test_t test_mode, // Test mode
  input wire logic sleep, // Sleep
  input wire logic por_req, // Reset pulse
  input wire logic nvm_busy, // Storing
  input wire logic key_valid, // Key loaded
  input wire logic [cfgcmd_pkg::CFG_DEPTH*8-1:0] cfg_image // Config memory
);
  import cfgcmd_pkg::*;
  logic [31:0] busy_cnt_reg;
  logic [31:0] exit_cnt_reg;
  logic [31:0] nid;
  logic id_addr;
  logic locked;
  assign nid = {cfg_image[199:192], cfg_image[207:200], cfg_image[215:208], cfg_image[223:216]};
  assign id_addr = remote_addr == CHAN_ADDR || remote_addr == RATE_ADDR ||
    (remote_addr >= MADDR_BASE && remote_addr <= NID_BASE + 8'h03);
  assign locked = id_addr && nid != NID_FACTORY;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt_reg <= '0;
      exit_cnt_reg <= '0;
    end else begin
      busy_cnt_reg <= nvm_busy ? busy_cnt_reg + 32'h1 : '0;
      exit_cnt_reg <= (por_req || exit_cnt_reg != 0) && cfg_active ? exit_cnt_reg + 32'h1 : '0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_exit_pulse_once: assert property (por_req |=> !por_req)
    else $error("exit pulse longer than one cycle");
  a_exit_from_cfg: assert property (por_req |-> cfg_active && cfg_n)
    else $error("exit pulse outside config mode");
  a_exit_bounded: assert property (exit_cnt_reg <= EXIT_CYCLES + 4)
    else $error("config mode kept after exit");
  a_exit_test_off: assert property ($fell(cfg_active) |-> test_mode == TEST_OFF && !sleep)
    else $error("test or sleep left on after exit");
  a_sleep_pin_low: assert property (cfg_n [*8] |-> !sleep)
    else $error("sleep with setup pin high");
  a_key_kept: assert property (key_valid |=> key_valid)
    else $error("loaded key lost");
  a_store_silent: assert property (nvm_busy |-> txd)
    else $error("transmit during storage");
  a_store_bounded: assert property (busy_cnt_reg <= MEM_PROG_CYCLES + 4)
    else $error("storage too long");
  a_remote_refused: assert property (remote_valid && locked |=> remote_denied)
    else $error("identity write not refused");
  a_remote_allowed: assert property (remote_valid && !locked |=> !remote_denied)
    else $error("allowed write refused");
  a_role_in_cfg: assert property ($changed(role) |-> $past(cfg_active))
    else $error("role changed outside config mode");
  c_exit: cover property (por_req);
  c_denied: cover property (remote_denied);
  c_key: cover property ($rose(key_valid));
  c_store: cover property ($fell(nvm_busy));
endmodule : cfg_cmd_interp_props
bind cfg_cmd_interp cfg_cmd_interp_props #(
  .MEM_PROG_CYCLES(MEM_PROG_CYCLES),
  .EXIT_CYCLES(EXIT_CYCLES)
) i_cfg_cmd_interp_props (.*);

// ---- sim/host_uart.sv ----
// Host serial model: sends bytes, collects replies
`timescale 1ns/10ps
module host_uart #(
  parameter int CLKS_PER_BIT = 16
) (
  input wire logic clk, // Clock
  output logic rxd, // Line to module
  input wire logic txd // Line from module
);
  initial rxd = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      #1 rxd = f[i];
      repeat (CLKS_PER_BIT - 1) @(posedge clk);
    end
  endtask : send
  task automatic recv(output logic [7:0] b);
    int n;
    b = 'x;
    n = 0;
    while (txd !== 1'b0 && n < 3000) begin
      @(posedge clk);
      #1 n++;
    end
    if (n < 3000) begin
      repeat (CLKS_PER_BIT / 2) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
        repeat (CLKS_PER_BIT) @(posedge clk);
        #1 if (i < 8) b[i] = txd;
      end
      if (txd !== 1'b1) b = 'x;
    end
  endtask : recv
endmodule : host_uart

// ---- sim/uart_config_command_interpreter_tb_top.sv ----
// Self-checking bench for the command interpreter
`timescale 1ns/10ps
module uart_config_command_interpreter_tb_top;
  import cfgcmd_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b1;
  logic gw_cfg_req = 1'b0, pkt_valid = 1'b0;
  logic [7:0] pkt_rssi = 8'ha1, pkt_info = 8'ha2;
  logic cfg_n = 1'b1;
  logic rxd, txd, remote_denied, cfg_active, sleep, por_req, nvm_busy, key_valid;
  logic remote_valid = 1'b0;
  logic [7:0] remote_addr = 8'h00;
  logic [7:0] remote_data = 8'h00;
  logic [7:0] rssi = 8'h91;
  logic [7:0] temperature = 8'h92;
  logic [7:0] supply = 8'h93;
  logic [127:0] key_data;
  logic [CFG_DEPTH*8-1:0] cfg_image;
  logic [CAL_DEPTH*8-1:0] cal_image;
  role_t role;
  test_t test_mode;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int por_seen = 0;
  int starts = 0;
  always #2.5 clk = ~clk;
  cfg_cmd_interp #(.CLKS_PER_BIT(16), .MEM_PROG_CYCLES(20), .EXIT_CYCLES(10)) i_cfg_cmd_interp (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .rxd(rxd), .txd(txd), .cfg_n(cfg_n),
    .gw_cfg_req(gw_cfg_req), .rssi(rssi), .temperature(temperature), .supply(supply),
    .pkt_valid(pkt_valid), .pkt_rssi(pkt_rssi), .pkt_info(pkt_info), .remote_valid(remote_valid),
    .remote_addr(remote_addr), .remote_data(remote_data), .remote_denied(remote_denied),
    .cfg_active(cfg_active), .role(role), .test_mode(test_mode), .sleep(sleep),
    .por_req(por_req), .nvm_busy(nvm_busy), .key_data(key_data), .key_valid(key_valid),
    .cfg_image(cfg_image), .cal_image(cal_image));
  host_uart #(.CLKS_PER_BIT(16)) i_host_uart (.clk(clk), .rxd(rxd), .txd(txd));
  always @(negedge txd) starts++;
  always @(posedge clk) begin
    if (por_req === 1'b1) por_seen++;
    cycles++;
    if (cycles == 60000) begin
      errors++;
      summarize();
    end
  end
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk
  task automatic tx(input logic [7:0] b);
    i_host_uart.send(b);
  endtask : tx
  task automatic rx(input logic [7:0] e);
    logic [7:0] b;
    i_host_uart.recv(b);
    chk(b, e);
  endtask : rx
  task automatic remote(input logic [7:0] a, input logic [7:0] d, input logic deny,
    input logic [7:0] e);
    @(posedge clk);
    #1 remote_valid = 1'b1;
    remote_addr = a;
    remote_data = d;
    @(posedge clk);
    #1 remote_valid = 1'b0;
    chk(remote_denied, deny);
    chk(cfg_image[8*int'(a)+:8], e);
  endtask : remote
  task automatic t_entry;
    @(posedge clk);
    #1 cfg_n = 1'b0;
    rx(PROMPT_CHAR);
    chk(cfg_active, 1'b1);
    tx(CMD_SLEEP);
    repeat (40) @(posedge clk);
    #1 chk(sleep, 1'b1);
    cfg_n = 1'b1;
    rx(PROMPT_CHAR);
    chk(sleep, 1'b0);
    $display("test entry done");
  endtask : t_entry
  task automatic t_cmds;
    logic [7:0] c [6];
    role_t r [3];
    c = '{CMD_RSSI, CMD_TEMP, CMD_VCC, CMD_ENDNODE, CMD_ROUTER, CMD_GATEWAY};
    r = '{ROLE_END, ROLE_ROUTER, ROLE_GATEWAY};
    foreach (c[i]) begin
      tx(c[i]);
      if (i < 3) rx(8'h91 + 8'(i));
      rx(PROMPT_CHAR);
      if (i >= 3) chk(role, r[i-3]);
    end
    tx(8'h41);
    rx(PROMPT_CHAR);
    tx(CMD_READ);
    tx(8'h80);
    rx(PROMPT_CHAR);
    tx(CMD_AT);
    tx(8'h41);
    rx(PROMPT_CHAR);
    $display("test commands done");
  endtask : t_cmds
  task automatic t_store;
    tx(CMD_MEMW);
    rx(PROMPT_CHAR);
    tx(8'h05);
    tx(8'ha5);
    tx(NID_BASE);
    tx(8'h12);
    tx(MEMW_END);
    rx(PROMPT_CHAR);
    tx(CMD_READ);
    tx(8'h05);
    rx(8'ha5);
    rx(PROMPT_CHAR);
    remote(CHAN_ADDR, 8'h07, 1'b1, 8'h00);
    remote(8'h10, 8'h3c, 1'b0, 8'h3c);
    tx(CMD_AT);
    tx(CMD_AT_T);
    rx(PROMPT_CHAR);
    chk(cfg_image === FACTORY_CFG, 1'b1);
    remote(CHAN_ADDR, 8'h07, 1'b0, 8'h07);
    $display("test store done");
  endtask : t_store
  task automatic t_key;
    logic [127:0] k;
    k = 128'h00112233445566778899aabbccddeeff;
    tx(CMD_KEY);
    tx(KEY_INDEX);
    rx(PROMPT_CHAR);
    for (int i = 15; i >= 0; i--) tx(k[8*i+:8]);
    rx(PROMPT_CHAR);
    chk(key_data, k);
    chk(key_valid, 1'b1);
    $display("test key done");
  endtask : t_key
  task automatic t_sniff;
    tx(CMD_TX_CARRIER);
    rx(PROMPT_CHAR);
    chk(test_mode, TEST_CARRIER);
    tx(CMD_SNIFF2);
    repeat (20) @(posedge clk);
    #1 pkt_valid = 1'b1;
    @(posedge clk);
    #1 pkt_valid = 1'b0;
    rx(8'ha1);
    rx(8'ha2);
    tx(8'h41);
    rx(PROMPT_CHAR);
    chk(test_mode, TEST_RX);
    $display("test sniff done");
  endtask : t_sniff
  task automatic t_exit;
    int s;
    s = starts;
    tx(CMD_EXIT);
    repeat (100) @(posedge clk);
    #1 chk(por_seen, 1);
    chk(starts, s);
    chk(cfg_active, 1'b0);
    gw_cfg_req = 1'b1;
    @(posedge clk);
    #1 gw_cfg_req = 1'b0;
    rx(PROMPT_CHAR);
    chk(cfg_active, 1'b1);
    $display("test exit done");
  endtask : t_exit
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize
  initial begin
    #1 rst_n = 1'b0;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (8) @(posedge clk);
    t_entry();
    t_cmds();
    t_store();
    t_key();
    t_sniff();
    t_exit();
    summarize();
  end
endmodule : uart_config_command_interpreter_tb_top
